// File: hw/bpt_defs.svh
/*
 * Constants of the buffered pwm timer base: widths, reset values.
 * Assumes inclusion by bare name from the prescaler and timer design files.
 */
`ifndef BPT_DEFS_SVH
`define BPT_DEFS_SVH

// data path widths
`define BPT_CNT_W 16
`define BPT_HALF_W 8
`define BPT_NCH 3
`define BPT_PSEL_W 3
`define BPT_PSC_W 7

// reset values
`define BPT_CNT_RST 16'h0000
`define BPT_PER_RST 16'hFFFF
`define BPT_CMP_RST 16'h0000
`define BPT_HALF_ZERO 8'h00
`define BPT_ONE 16'h0001
`define BPT_HALF_ONE 8'h01

`endif

// File: hw/bpt_pkg.sv
/*
 * Types shared by the buffered pwm timer base.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package bpt_pkg;
    // waveform generation mode
    typedef enum logic [1:0] {
        WAVE_NORMAL,
        WAVE_FRQ,
        WAVE_SINGLE,
        WAVE_DUAL
    } bpt_wave_t;

    // what an event input does
    typedef enum logic [1:0] {
        EVACT_COUNT,
        EVACT_DIR,
        EVACT_RESTART
    } bpt_evact_t;

    // dual-slope direction state
    typedef enum logic {
        SLOPE_UP,
        SLOPE_DOWN
    } bpt_slope_t;
endpackage : bpt_pkg

`default_nettype wire

// File: hw/bpt_prescaler.sv
/*
 * Prescaler: divides the peripheral clock by 2**select into ticks.
 * Assumes select is held steady while the timer runs.
 */
`include "bpt_defs.svh"
`default_nettype none

module bpt_prescaler #(
    parameter int PSC_W = `BPT_PSC_W
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // control
    input wire logic run_i,
    input wire logic [`BPT_PSEL_W-1:0] sel_i,
    // tick out
    output logic tick_o
);
    logic [PSC_W-1:0] div_q;
    logic [PSC_W-1:0] limit_c;

    assign limit_c = PSC_W'((1 << sel_i) - 1);

    // divider restarts whenever the timer stops, so phase is fresh
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= '0;
        end else if (!run_i || div_q >= limit_c) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + PSC_W'(1);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= run_i && div_q >= limit_c;
        end
    end

    // no tick while stopped
    property p_psc_idle;
        @(posedge sys_clk_i) disable iff (rst_i)
        !run_i |=> !tick_o;
    endproperty
    a_psc_idle: assert property (p_psc_idle)
        else $error("prescaler ticked while stopped");
endmodule : bpt_prescaler

`default_nettype wire

// File: hw/bpt_timer.sv
/*
 * Buffered pwm timer base: 16-bit counter, period, three compare
 * channels with double buffers, split mode and event control.
 * Assumes all inputs synchronous to sys_clk_i and one-cycle writes.
 */
// Function
// - counter, period, compares and buffers are 16 bits; three channels
// - split mode gives two independent 8-bit timers
// - three waveform outputs except in non-split normal mode, three more only in split mode
// - events may count, steer direction or restart the counter
// - count clock comes from a prescaler chosen by prescale select
// - counter is compared with zero and period continuously
// - bottom is zero, max all ones, top the sequence maximum
// - update happens at top when counting up, at bottom when counting down or in dual-slope
// - enable starts counting prescaled ticks
// - event count enable counts events instead of ticks
// - normal counting follows the direction bit
// - up-count past top wraps to zero next tick
// - down-count at bottom reloads the period
// - counter write wins over count, clear and reload
// - direction may change while running
// - period and each compare have a buffer
// - each buffer has a readable valid flag
// - buffer write sets valid; update clears it
// - update copies a valid period buffer into the period
// - active compares are directly writable, bypassing buffers
// - each compare equality is a match driving flags and frequency-mode waves
// - a match while the timer runs sets the channel flag next cycle
// - debug halt stops the timer unless debug run is set
`include "bpt_defs.svh"
`default_nettype none

module bpt_timer #(
    parameter int NCH = `BPT_NCH
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // main control
    input wire logic enable_i,
    input wire logic [`BPT_PSEL_W-1:0] prescale_select_i,
    input wire bpt_pkg::bpt_wave_t wave_mode_i,
    input wire logic split_i,
    input wire logic direction_down_i,
    // debug control
    input wire logic debug_halt_i,
    input wire logic debug_run_i,
    // event input control
    input wire logic event_count_enable_i,
    input wire bpt_pkg::bpt_evact_t event_action_i,
    input wire logic event_i,
    // counter and period writes
    input wire logic cnt_wr_i,
    input wire logic [`BPT_CNT_W-1:0] cnt_wdata_i,
    input wire logic per_wr_i,
    input wire logic period_buffer_wr_i,
    input wire logic [`BPT_CNT_W-1:0] per_wdata_i,
    // compare writes
    input wire logic [NCH-1:0] cmp_wr_i,
    input wire logic [NCH-1:0] cmpbuf_wr_i,
    input wire logic [`BPT_CNT_W-1:0] cmp_wdata_i,
    // flag clears
    input wire logic [NCH-1:0] cmp_flag_clr_i,
    input wire logic ovf_flag_clr_i,
    // state
    output logic [`BPT_CNT_W-1:0] counter_value_o,
    output logic [`BPT_CNT_W-1:0] period_o,
    output logic period_buffer_valid_o,
    output logic [NCH-1:0] compare_buffer_valid_o,
    output logic [NCH-1:0] compare_flag_o,
    output logic overflow_flag_o,
    output logic overflow_event_o,
    output logic update_o,
    // waveform lines
    output logic [2*NCH-1:0] waveform_out_o
);
    localparam int W = `BPT_CNT_W;
    localparam int H = `BPT_HALF_W;

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic [W-1:0] per_q;
    logic [W-1:0] period_buffer_q;
    logic period_buffer_valid_q;
    bpt_pkg::bpt_slope_t slope_q;
    bpt_pkg::bpt_slope_t slope_d;
    logic ev_q;
    logic ev_rise_c;
    logic run_c;
    logic psc_tick;
    logic tick_c;
    logic restart_c;
    logic down_c;
    logic top_c;
    logic bot_c;
    logic upd_c;
    logic [W-1:0] cmp_q [NCH];
    logic [W-1:0] cmpbuf_q [NCH];
    logic [NCH-1:0] cmpbv_q;
    logic [NCH-1:0] mat_c;
    logic [2*NCH-1:0] wo_q;
    logic [NCH-1:0] flag_q;

    assign run_c = enable_i && (!debug_halt_i || debug_run_i);

    assign ev_rise_c = event_i && !ev_q;
    assign restart_c = run_c && ev_rise_c
        && event_action_i == bpt_pkg::EVACT_RESTART;
    assign down_c = (event_action_i == bpt_pkg::EVACT_DIR)
        ? event_i : direction_down_i;

    assign tick_c = run_c && (event_count_enable_i
        ? (ev_rise_c && event_action_i == bpt_pkg::EVACT_COUNT)
        : psc_tick);

    assign bot_c = (cnt_q == `BPT_CNT_RST);
    // dual-slope also turns if the period was lowered below the count
    assign top_c = (wave_mode_i == bpt_pkg::WAVE_DUAL)
        ? (cnt_q >= per_q) : (cnt_q == per_q);

    bpt_prescaler #(
        .PSC_W(`BPT_PSC_W)
    ) u_psc (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .run_i(run_c),
        .sel_i(prescale_select_i),
        .tick_o(psc_tick)
    );

    // next counter value and update condition
    always_comb begin
        cnt_d = cnt_q;
        slope_d = slope_q;
        upd_c = 1'b0;
        if (cnt_wr_i) begin
            cnt_d = cnt_wdata_i;
        end else if (restart_c) begin
            cnt_d = `BPT_CNT_RST;
            slope_d = bpt_pkg::SLOPE_UP;
        end else if (tick_c) begin
            if (split_i) begin
                upd_c = (cnt_q[H-1:0] == `BPT_HALF_ZERO);
                cnt_d[H-1:0] = upd_c ? per_q[H-1:0]
                    : cnt_q[H-1:0] - `BPT_HALF_ONE;
                cnt_d[W-1:H] = (cnt_q[W-1:H] == `BPT_HALF_ZERO)
                    ? per_q[W-1:H] : cnt_q[W-1:H] - `BPT_HALF_ONE;
            end else if (wave_mode_i == bpt_pkg::WAVE_DUAL) begin
                case (slope_q)
                    bpt_pkg::SLOPE_UP: begin
                        if (top_c) begin
                            slope_d = bpt_pkg::SLOPE_DOWN;
                            cnt_d = cnt_q - `BPT_ONE;
                        end else begin
                            cnt_d = cnt_q + `BPT_ONE;
                        end
                    end
                    default: begin
                        if (bot_c) begin
                            upd_c = 1'b1;
                            slope_d = bpt_pkg::SLOPE_UP;
                            cnt_d = cnt_q + `BPT_ONE;
                        end else begin
                            cnt_d = cnt_q - `BPT_ONE;
                        end
                    end
                endcase
            end else if (down_c) begin
                upd_c = bot_c;
                cnt_d = bot_c ? per_q : cnt_q - `BPT_ONE;
            end else begin
                upd_c = top_c;
                cnt_d = top_c ? `BPT_CNT_RST : cnt_q + `BPT_ONE;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= `BPT_CNT_RST;
            slope_q <= bpt_pkg::SLOPE_UP;
            ev_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            slope_q <= slope_d;
            ev_q <= event_i;
        end
    end

    // period with buffer; a buffer write beats the clear
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            per_q <= `BPT_PER_RST;
            period_buffer_q <= `BPT_PER_RST;
            period_buffer_valid_q <= 1'b0;
        end else begin
            if (per_wr_i) begin
                per_q <= per_wdata_i;
            end else if (upd_c && period_buffer_valid_q) begin
                per_q <= period_buffer_q;
            end
            if (period_buffer_wr_i) begin
                period_buffer_q <= per_wdata_i;
            end
            if (period_buffer_wr_i) begin
                period_buffer_valid_q <= 1'b1;
            end else if (upd_c) begin
                period_buffer_valid_q <= 1'b0;
            end
        end
    end

    // compare channels
    for (genvar n = 0; n < NCH; n++) begin : g_ch
        assign mat_c[n] = split_i
            ? (cnt_q[H-1:0] == cmp_q[n][H-1:0])
            : (cnt_q == cmp_q[n]);

        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                cmp_q[n] <= `BPT_CMP_RST;
                cmpbuf_q[n] <= `BPT_CMP_RST;
                cmpbv_q[n] <= 1'b0;
            end else begin
                if (cmp_wr_i[n]) begin
                    cmp_q[n] <= cmp_wdata_i;
                end else if (upd_c && cmpbv_q[n]) begin
                    cmp_q[n] <= cmpbuf_q[n];
                end
                if (cmpbuf_wr_i[n]) begin
                    cmpbuf_q[n] <= cmp_wdata_i;
                end
                if (cmpbuf_wr_i[n]) begin
                    cmpbv_q[n] <= 1'b1;
                end else if (upd_c) begin
                    cmpbv_q[n] <= 1'b0;
                end
            end
        end

        // sticky match flag, set beats clear
        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                flag_q[n] <= 1'b0;
            end else begin
                flag_q[n] <= (run_c && mat_c[n])
                    || (flag_q[n] && !cmp_flag_clr_i[n]);
            end
        end

        // low waveform lines, one cycle behind the counter
        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                wo_q[n] <= 1'b0;
            end else if (split_i) begin
                wo_q[n] <= cnt_q[H-1:0] < cmp_q[n][H-1:0];
            end else begin
                case (wave_mode_i)
                    bpt_pkg::WAVE_FRQ:
                        wo_q[n] <= wo_q[n] ^ (tick_c && mat_c[n]);
                    bpt_pkg::WAVE_SINGLE,
                    bpt_pkg::WAVE_DUAL:
                        wo_q[n] <= cnt_q < cmp_q[n];
                    default:
                        wo_q[n] <= 1'b0;
                endcase
            end
        end

        // high lines only live in split mode
        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                wo_q[n+NCH] <= 1'b0;
            end else begin
                wo_q[n+NCH] <= split_i
                    && cnt_q[W-1:H] < cmp_q[n][W-1:H];
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            overflow_flag_o <= 1'b0;
            overflow_event_o <= 1'b0;
            update_o <= 1'b0;
        end else begin
            overflow_flag_o <= upd_c
                || (overflow_flag_o && !ovf_flag_clr_i);
            overflow_event_o <= upd_c;
            update_o <= upd_c;
        end
    end

    // state outputs are the registers themselves
    assign counter_value_o = cnt_q;
    assign period_o = per_q;
    assign period_buffer_valid_o = period_buffer_valid_q;
    assign compare_buffer_valid_o = cmpbv_q;
    assign compare_flag_o = flag_q;
    assign waveform_out_o = wo_q;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_cnt_wr;
        cnt_wr_i |=> counter_value_o == $past(cnt_wdata_i);
    endproperty
    a_cnt_wr: assert property (p_cnt_wr)
        else $error("counter write not taken");

    property p_up_wrap;
        tick_c && !cnt_wr_i && !restart_c && !split_i && !down_c
        && wave_mode_i != bpt_pkg::WAVE_DUAL && top_c
        |=> counter_value_o == `BPT_CNT_RST && overflow_event_o;
    endproperty
    a_up_wrap: assert property (p_up_wrap)
        else $error("up count did not wrap at top");

    property p_dn_reload;
        tick_c && !cnt_wr_i && !restart_c && !split_i && down_c
        && wave_mode_i != bpt_pkg::WAVE_DUAL && bot_c
        |=> counter_value_o == $past(per_q);
    endproperty
    a_dn_reload: assert property (p_dn_reload)
        else $error("down count did not reload period");

    property p_bv_set;
        period_buffer_wr_i |=> period_buffer_valid_o;
    endproperty
    a_bv_set: assert property (p_bv_set)
        else $error("period buffer valid not set");

    property p_per_copy;
        upd_c && period_buffer_valid_q && !per_wr_i
        |=> period_o == $past(period_buffer_q) && update_o;
    endproperty
    a_per_copy: assert property (p_per_copy)
        else $error("period buffer not copied on update");

    property p_halt;
        debug_halt_i && !debug_run_i && !cnt_wr_i
        |=> $stable(counter_value_o);
    endproperty
    a_halt: assert property (p_halt)
        else $error("counter moved during debug halt");

    property p_ovf;
        upd_c |=> overflow_flag_o && overflow_event_o && update_o;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow flag or event missing");

    property p_wo_hi;
        !split_i ##1 !split_i |-> waveform_out_o[2*NCH-1:NCH] == '0;
    endproperty
    a_wo_hi: assert property (p_wo_hi)
        else $error("split-only waveform line driven");

    property p_match;
        run_c && mat_c[0] |=> compare_flag_o[0];
    endproperty
    a_match: assert property (p_match)
        else $error("compare flag not set after match");

    property p_enable;
        !enable_i |=> $stable(counter_value_o) || $past(cnt_wr_i);
    endproperty
    a_enable: assert property (p_enable)
        else $error("counter moved while disabled");

    // main scenarios
    c_wrap: cover property (tick_c && top_c && !down_c);
    c_reload: cover property (tick_c && bot_c && down_c);
    c_copy: cover property (upd_c && period_buffer_valid_q);
    c_split: cover property (split_i && upd_c);
endmodule : bpt_timer

`default_nettype wire

// File: verif/bpt_event_src.sv
/*
 * Event channel model: sends a burst of n rising edges on request.
 * Assumes go_i is a one-cycle pulse from the bench.
 */
`default_nettype none

module bpt_event_src (
    // clock
    input wire logic sys_clk_i,
    // request
    input wire logic [3:0] n_i,
    input wire logic go_i,
    // event line
    output logic event_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int left = 0;

    initial event_o = 1'b0;

    // one cycle high, one low: each rising edge is one event
    always @(posedge sys_clk_i) begin
        if (go_i) begin
            left <= 2 * n_i;
        end else if (left > 0) begin
            event_o <= !event_o;
            left <= left - 1;
        end
    end
endmodule : bpt_event_src

`default_nettype wire

// File: verif/tb_bpt_timer.sv
/*
 * Bench of the timer base: an integer cycle model follows counter,
 * period, buffers and flags and is compared with the design each cycle while it stays in sync.
 * Assumes the package and design files are compiled first.
 */
`default_nettype none
`define BPT_CHK(nm, ex, got) begin checks_done++; \
    if ((got) !== (ex)) begin failures++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end

module tb_bpt_timer;
    timeunit 1ns;
    timeprecision 1ns;
    // design inputs
    logic sys_clk_i = 1'b0, rst_i = 1'b1, enable_i = 1'b0;
    logic split_i = 1'b0, direction_down_i = 1'b0;
    logic debug_halt_i = 1'b0, debug_run_i = 1'b0;
    logic event_count_enable_i = 1'b0, cnt_wr_i = 1'b0;
    logic per_wr_i = 1'b0, period_buffer_wr_i = 1'b0, ovf_flag_clr_i = 1'b0;
    logic [2:0] prescale_select_i = 3'h0, cmp_wr_i = 3'h0;
    logic [2:0] cmpbuf_wr_i = 3'h0, cmp_flag_clr_i = 3'h0;
    logic [15:0] cnt_wdata_i = 16'h0000, per_wdata_i = 16'h0000;
    logic [15:0] cmp_wdata_i = 16'h0000;
    bpt_pkg::bpt_wave_t wave_mode_i = bpt_pkg::WAVE_NORMAL;
    bpt_pkg::bpt_evact_t event_action_i = bpt_pkg::EVACT_COUNT;
    wire logic event_i;
    // design outputs
    wire logic [15:0] counter_value_o, period_o;
    wire logic period_buffer_valid_o, overflow_flag_o;
    wire logic overflow_event_o, update_o;
    wire logic [2:0] compare_buffer_valid_o, compare_flag_o;
    wire logic [5:0] waveform_out_o;
    // partner request and bench state
    logic [3:0] ev_n = 4'h0;
    logic ev_go = 1'b0;
    int failures = 0, checks_done = 0, cycles = 0, p, v;
    int m_cnt, m_per, m_pbuf, m_cmp[3], m_cbuf[3];
    bit m_pbv, m_upd, m_ovf, m_tick, m_sync, up;
    bit [2:0] m_cbv, m_cf;
    wire logic run = enable_i && !(debug_halt_i && !debug_run_i);

    bpt_timer uut (
        .sys_clk_i, .rst_i, .enable_i, .prescale_select_i, .wave_mode_i,
        .split_i, .direction_down_i, .debug_halt_i, .debug_run_i,
        .event_count_enable_i, .event_action_i, .event_i, .cnt_wr_i,
        .cnt_wdata_i, .per_wr_i, .period_buffer_wr_i, .per_wdata_i, .cmp_wr_i,
        .cmpbuf_wr_i, .cmp_wdata_i, .cmp_flag_clr_i, .ovf_flag_clr_i,
        .counter_value_o, .period_o, .period_buffer_valid_o,
        .compare_buffer_valid_o, .compare_flag_o, .overflow_flag_o,
        .overflow_event_o, .update_o, .waveform_out_o
    );

    bpt_event_src evs (
        .sys_clk_i, .n_i(ev_n), .go_i(ev_go), .event_o(event_i)
    );

    // 20 MHz clock
    always #25 sys_clk_i = ~sys_clk_i;

    // hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end

    // cycle model; event, restart and split modes are not modelled
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            m_cnt = 0;
            m_per = 'hFFFF;
            m_pbuf = 'hFFFF;
            m_cmp = '{0, 0, 0};
            m_cbuf = '{0, 0, 0};
            {m_pbv, m_cbv, m_cf, m_ovf, m_upd, m_tick} = '0;
            m_sync = 1'b1;
        end else begin
            up = 1'b0;
            // a match while running sets the flag a cycle later
            for (int n = 0; n < 3; n++) begin
                if (run && m_cnt == m_cmp[n])
                    m_cf[n] = 1'b1;
                else if (cmp_flag_clr_i[n])
                    m_cf[n] = 1'b0;
            end
            if (ovf_flag_clr_i)
                m_ovf = 1'b0;
            // ticks lag run by a cycle; a write wins
            if (cnt_wr_i) begin
                m_cnt = cnt_wdata_i;
            end else if (m_tick && run) begin
                // wrap at top, reload at bottom
                if (direction_down_i) begin
                    up = (m_cnt == 0);
                    m_cnt = up ? m_per : m_cnt - 1;
                end else begin
                    up = (m_cnt == m_per);
                    m_cnt = up ? 0 : (m_cnt + 1) % 65536;
                end
            end
            m_upd = up;
            if (up)
                m_ovf = 1'b1;
            // writes, valid flags, copy at update
            if (per_wr_i)
                m_per = per_wdata_i;
            else if (up && m_pbv)
                m_per = m_pbuf;
            if (period_buffer_wr_i) begin
                m_pbuf = per_wdata_i;
                m_pbv = 1'b1;
            end else if (up) begin
                m_pbv = 1'b0;
            end
            for (int n = 0; n < 3; n++) begin
                if (cmp_wr_i[n])
                    m_cmp[n] = cmp_wdata_i;
                else if (up && m_cbv[n])
                    m_cmp[n] = m_cbuf[n];
                if (cmpbuf_wr_i[n]) begin
                    m_cbuf[n] = cmp_wdata_i;
                    m_cbv[n] = 1'b1;
                end else if (up) begin
                    m_cbv[n] = 1'b0;
                end
            end
            // a stop of run leaves one tick open: wait for a write
            m_sync = (m_sync || cnt_wr_i) && !(m_tick && !run)
                && !event_count_enable_i && !split_i
                && prescale_select_i == 3'h0
                && event_action_i == bpt_pkg::EVACT_COUNT;
            m_tick = run;
        end
    end

    // compare design with model every cycle in which the model is in sync
    always @(negedge sys_clk_i) begin
        if (!rst_i && !split_i)
            `BPT_CHK("wave_hi", 3'h0, waveform_out_o[5:3])
        if (!rst_i && !split_i && wave_mode_i == bpt_pkg::WAVE_NORMAL)
            `BPT_CHK("wave_lo", 3'h0, waveform_out_o[2:0])
        if (!rst_i && m_sync) begin
            `BPT_CHK("counter", m_cnt, counter_value_o)
            `BPT_CHK("period", m_per, period_o)
            `BPT_CHK("per_valid", m_pbv, period_buffer_valid_o)
            `BPT_CHK("cmp_valid", m_cbv, compare_buffer_valid_o)
            `BPT_CHK("cmp_flag", m_cf, compare_flag_o)
            `BPT_CHK("ovf_flag", m_ovf, overflow_flag_o)
            `BPT_CHK("ovf_event", m_upd, overflow_event_o)
            `BPT_CHK("update", m_upd, update_o)
        end
    end

    task cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : cyc

    // one-cycle strobe: 0 cnt, 1 per, 2 period_buffer, 3 cmp, 4 cmpbuf, 5 clr
    task wr(input int k, input int n, input logic [15:0] d);
        @(posedge sys_clk_i);
        cnt_wdata_i <= d;
        per_wdata_i <= d;
        cmp_wdata_i <= d;
        case (k)
            0: cnt_wr_i <= 1'b1;
            1: per_wr_i <= 1'b1;
            2: period_buffer_wr_i <= 1'b1;
            3: cmp_wr_i[n] <= 1'b1;
            4: cmpbuf_wr_i[n] <= 1'b1;
            default: begin
                cmp_flag_clr_i <= 3'h7;
                ovf_flag_clr_i <= 1'b1;
            end
        endcase
        @(posedge sys_clk_i);
        {cnt_wr_i, per_wr_i, period_buffer_wr_i, ovf_flag_clr_i} <= 4'h0;
        {cmp_wr_i, cmpbuf_wr_i, cmp_flag_clr_i} <= 9'h000;
    endtask : wr

    task final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    initial begin
        void'($urandom(84285));
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        // up-count wraps at a random top
        p = 10 + $urandom % 20;
        wr(1, 0, 16'(p));
        enable_i <= 1'b1;
        cyc(3 * p);
        // turn down mid-run, then back up
        direction_down_i <= 1'b1;
        cyc(2 * p);
        direction_down_i <= 1'b0;
        // staged period taken at the next update
        v = 10 + $urandom % 20;
        wr(2, 0, 16'(v));
        cyc(2 * p + 4);
        p = v;
        // compares written direct and buffered, then the flags cleared
        for (int n = 0; n < 3; n++) begin
            wr(3, n, 16'($urandom % p));
            wr(4, n, 16'($urandom % p));
        end
        cyc(2 * p + 4);
        wr(5, 0, 16'h0000);
        cyc(p);
        // counter writes away from the wrap point
        repeat (8) begin
            do @(negedge sys_clk_i); while (m_cnt + 6 > m_per);
            wr(0, 0, 16'($urandom % p));
            cyc($urandom % 5);
        end
        // halt runs on with debug run, stops without
        debug_halt_i <= 1'b1;
        debug_run_i <= 1'b1;
        cyc(p);
        debug_run_i <= 1'b0;
        cyc(3);
        wr(0, 0, 16'h0004);
        cyc(6);
        debug_halt_i <= 1'b0;
        cyc(p);
        // select 2: one tick every 4 cycles from a fresh divider
        prescale_select_i <= 3'h2;
        enable_i <= 1'b0;
        wr(0, 0, 16'h0000);
        enable_i <= 1'b1;
        cyc(21);
        @(negedge sys_clk_i);
        `BPT_CHK("prescaled", 16'h0005, counter_value_o)
        prescale_select_i <= 3'h0;
        event_count_enable_i <= 1'b1;
        wr(1, 0, 16'hFFFF);
        wr(0, 0, 16'h0000);
        cyc(2);
        ev_n <= 4'h5;
        ev_go <= 1'b1;
        cyc(1);
        ev_go <= 1'b0;
        cyc(16);
        @(negedge sys_clk_i);
        `BPT_CHK("event_count", 16'h0005, counter_value_o)
        // a restart event clears the running counter
        event_count_enable_i <= 1'b0;
        event_action_i <= bpt_pkg::EVACT_RESTART;
        wr(0, 0, 16'h0100);
        ev_n <= 4'h1;
        ev_go <= 1'b1;
        cyc(1);
        ev_go <= 1'b0;
        cyc(6);
        @(negedge sys_clk_i);
        `BPT_CHK("restart", 1'b1, counter_value_o < 16'h0010)
        // split halves count down and reload on their own
        event_action_i <= bpt_pkg::EVACT_COUNT;
        split_i <= 1'b1;
        direction_down_i <= 1'b1;
        wr(1, 0, 16'h0305);
        wr(0, 0, 16'h0000);
        repeat (24) begin
            @(negedge sys_clk_i);
            `BPT_CHK("split_lo", 1'b1, counter_value_o[7:0] <= 8'h05)
            `BPT_CHK("split_hi", 1'b1, counter_value_o[15:8] <= 8'h03)
        end
        final_report();
    end
endmodule : tb_bpt_timer

`default_nettype wire
